/* File: logic/mode_cfg.sv */
// Mode registers zero and one with burst ordering and DLL control
`timescale 1ns/1ps
module mode_cfg
  import mode_cfg_pkg::*;
#(
  parameter int DLL_RST_CYCLES = 4
) (
  input  wire logic                           CLK,
  input  wire logic                           NRST,
  input  wire logic                           CKE_EN,
  input  wire logic                           CS_N,
  input  wire logic                           RAS_N,
  input  wire logic                           CAS_N,
  input  wire logic                           WE_N,
  input  wire logic [mode_cfg_pkg::BANK_W-1:0] BA,
  input  wire logic [mode_cfg_pkg::ADDR_W-1:0] ADDR,
  input  wire logic                           SR_ENTER,
  input  wire logic                           SR_EXIT,
  output logic                                BEAT_VALID,
  output logic [mode_cfg_pkg::COL_W-1:0]      BEAT_COL,
  output logic                                BEAT_IS_WRITE,
  output logic                                DQ_OE,
  output logic                                BURST_BUSY,
  output logic                                WRITE_START,
  output logic                                DLL_ON,
  output logic                                DLL_RESET_ACTIVE,
  output logic                                PD_DLL_FAST,
  output logic [2:0]                          WR_RECOVERY,
  output logic [3:0]                          READ_CL_CODE,
  output logic [1:0]                          ADD_LAT_CODE,
  output logic [1:0]                          DRIVE_STRENGTH,
  output logic [2:0]                          RTT_NOM,
  output logic                                WRITE_LEVEL,
  output logic                                OUTPUTS_OFF,
  output logic                                TEST_MODE
);
  import mode_cfg_pkg::*;

  localparam int CMDW = COL_W + 2;
  // Sync stages leave reset at idle pin levels, so no false command or refresh follows
  localparam logic [ADDR_W+BANK_W+5:0] PIN_IDLE = {4'hF, 2'h0, (ADDR_W+BANK_W)'(0)};
  // Beat at which the internal write starts; fixed chop pulls it
  localparam logic [3:0] WS_BEAT_FULL  = BEATS8 - 4'(WR_PULLIN) - 4'h1;
  localparam logic [3:0] WS_BEAT_EARLY = WS_BEAT_FULL - 4'(WR_PULLIN);
  // Clear of the DLL reset flag, counted from its rise
  localparam int DLL_CLR_LAT = DLL_RST_CYCLES + 1;

  typedef struct packed {
    logic              early_ws;
    logic [ADDR_W-1:0] mr0;
    logic [ADDR_W-1:0] mr1;
    logic [3:0]        dll_cnt;
    logic              dll_rst;
    logic              sr_dll_off;
    logic [3:0]        beat;
    logic [3:0]        len;
    logic [COL_W-1:0]  start;
    logic              wr;
    logic              il;
    logic              chop;
    logic              busy;
    logic              out_v;
    logic [COL_W-1:0]  out_col;
    logic              out_w;
    logic              out_oe;
    logic              wstart;
  } st_t;

  st_t st_q;
  st_t st_d;

  // Pin sync stages: first stage is read only by the second
  logic [ADDR_W+BANK_W+6-1:0] pin_s1;
  logic [ADDR_W+BANK_W+6-1:0] pin_s2;
  logic                       cs_n_s, ras_n_s, cas_n_s, we_n_s, sre_s, srx_s;
  logic [BANK_W-1:0]          ba_s;
  logic [ADDR_W-1:0]          a_s;

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
    end
    else if (CKE_EN)
    begin
      pin_s1 <= {CS_N, RAS_N, CAS_N, WE_N, SR_ENTER, SR_EXIT, BA, ADDR};
      pin_s2 <= pin_s1;
    end
  end
  assign {cs_n_s, ras_n_s, cas_n_s, we_n_s, sre_s, srx_s, ba_s, a_s} = pin_s2;

  logic cmd_mrs, cmd_rd, cmd_wr;
  assign cmd_mrs = ~cs_n_s & ~ras_n_s & ~cas_n_s & ~we_n_s;
  assign cmd_rd  = ~cs_n_s & ras_n_s & ~cas_n_s & we_n_s;
  assign cmd_wr  = ~cs_n_s & ras_n_s & ~cas_n_s & ~we_n_s;

  // Column of beat i for a given order and start
  function automatic logic [COL_W-1:0] beat_col(input logic il, input logic [COL_W-1:0] s,
                                                input logic [2:0] i);
    logic [COL_W-1:0] c;
    c = '0;
    if (il)
      c = s ^ i;
    else
      c = {s[2] ^ i[2], 2'(s[1:0] + i[1:0])};
    return c;
  endfunction

  // Queue of burst commands {write, chop, start column}
  burst_if #(.W(CMDW)) q ();
  beat_fifo #(.W(CMDW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .CLK  (CLK),
    .NRST (NRST),
    .CE   (CKE_EN),
    .bus  (q)
  );

  logic [1:0] bl_code;
  logic       req_chop;
  assign bl_code  = st_q.mr0[MR0_BL_LO +: 2];
  // Chop when fixed four, or on-the-fly with selection pin low
  assign req_chop = (bl_code == BL_FIX4) || ((bl_code == BL_OTF) && !a_s[BC_SEL]);
  assign q.in_valid  = cmd_rd | cmd_wr;
  assign q.in_data   = {cmd_wr, req_chop, a_s[COL_W-1:0]};
  // Commands are queued immediately and run one burst at a time
  assign q.out_ready = !st_q.busy;

  // Main next-state logic
  always_comb
  begin
    st_d        = st_q;
    st_d.out_v  = 1'b0;
    st_d.out_oe = 1'b0;
    st_d.wstart = 1'b0;
    // Mode register loads by bank select
    if (cmd_mrs && ba_s == BANK_MR0)
    begin
      st_d.mr0 = a_s;
      if (a_s[MR0_DLLRST])
      begin
        st_d.dll_rst = 1'b1;
        st_d.dll_cnt = 4'(DLL_RST_CYCLES);
      end
    end
    if (cmd_mrs && ba_s == BANK_MR1)
      st_d.mr1 = a_s;
    // Self-clearing DLL reset after the reset interval
    if (st_q.dll_rst && !(cmd_mrs && ba_s == BANK_MR0 && a_s[MR0_DLLRST]))
    begin
      if (st_q.dll_cnt == 4'h0)
      begin
        st_d.dll_rst = 1'b0;
        st_d.mr0[MR0_DLLRST] = 1'b0;
      end
      else
        st_d.dll_cnt = st_q.dll_cnt - 4'h1;
    end
    // Self refresh gates an enabled DLL
    if (sre_s)
      st_d.sr_dll_off = 1'b1;
    else if (srx_s)
      st_d.sr_dll_off = 1'b0;
    // Burst sequencer
    if (!st_q.busy && q.out_valid)
    begin
      st_d.busy  = 1'b1;
      st_d.beat  = 4'h0;
      st_d.wr    = q.out_data[CMDW-1];
      st_d.chop  = q.out_data[CMDW-2];
      st_d.len   = q.out_data[CMDW-2] ? BEATS4 : BEATS8;
      st_d.il    = st_q.mr0[MR0_BT];
      // Writes start aligned; chop keeps A2 only
      st_d.start = q.out_data[CMDW-1] ?
                   (q.out_data[CMDW-2] ? {q.out_data[2], 2'h0} : 3'h0) : q.out_data[2:0];
      // Fixed chop pulls the internal write start
      st_d.early_ws = q.out_data[CMDW-1] && (bl_code == BL_FIX4);
    end
    else if (st_q.busy)
    begin
      st_d.out_v   = 1'b1;
      st_d.out_w   = st_q.wr;
      st_d.out_col = beat_col(st_q.il && !st_q.wr, st_q.start, st_q.beat[2:0]);
      // Drive only in the first four slots of a chop
      st_d.out_oe  = !st_q.wr && (st_q.beat < st_q.len) && !st_q.mr1[MR1_QOFF];
      st_d.beat    = st_q.beat + 4'h1;
      // On-the-fly chop keeps the eight-beat start point
      if (st_q.wr && st_q.beat == (st_q.early_ws ? WS_BEAT_EARLY : WS_BEAT_FULL))
        st_d.wstart = 1'b1;
      if (st_q.beat == BEATS8 - 4'h1)
        st_d.busy = 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      st_q     <= '0;
      st_q.mr0 <= REG_RESET;
      st_q.mr1 <= REG_RESET;
    end
    else if (CKE_EN)
      st_q <= st_d;
  end

  // Burst and configuration outputs
  assign BEAT_VALID       = st_q.out_v;
  assign BEAT_COL         = st_q.out_col;
  assign BEAT_IS_WRITE    = st_q.out_w;
  assign DQ_OE            = st_q.out_oe;
  assign BURST_BUSY       = st_q.busy;
  assign WRITE_START      = st_q.wstart;
  assign DLL_ON           = !st_q.mr1[MR1_DLLDIS] && !st_q.sr_dll_off;
  assign DLL_RESET_ACTIVE = st_q.dll_rst;
  assign PD_DLL_FAST      = st_q.mr0[MR0_PPD];
  assign WR_RECOVERY      = st_q.mr0[MR0_WR_LO +: 3];
  assign READ_CL_CODE     = {st_q.mr0[MR0_CL_LO +: 3], st_q.mr0[MR0_CL_B0]};
  assign ADD_LAT_CODE     = st_q.mr1[MR1_AL_LO +: 2];
  assign DRIVE_STRENGTH   = {st_q.mr1[MR1_DIC1], st_q.mr1[MR1_DIC0]};
  assign RTT_NOM          = {st_q.mr1[MR1_RTT2], st_q.mr1[MR1_RTT1], st_q.mr1[MR1_RTT0]};
  assign WRITE_LEVEL      = st_q.mr1[MR1_WLVL];
  assign OUTPUTS_OFF      = st_q.mr1[MR1_QOFF];
  assign TEST_MODE        = st_q.mr0[MR0_TM];

  // Assertions
  property p_dll_clear;
    @(posedge CLK) disable iff (!NRST || !CKE_EN)
    $rose(st_q.dll_rst) |-> ##[DLL_CLR_LAT:DLL_CLR_LAT]
      !st_q.dll_rst && !st_q.mr0[MR0_DLLRST];
  endproperty
  a_dll_clear: assert property (p_dll_clear) else $error("dll reset not cleared");

  property p_il;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && st_q.busy && st_q.il && !st_q.wr |=> !CKE_EN || BEAT_COL == ($past(st_q.start)
      ^ $past(st_q.beat[2:0]));
  endproperty
  a_il: assert property (p_il) else $error("interleave order wrong");

  property p_seq;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && st_q.busy && !st_q.il && !st_q.wr |=> !CKE_EN
      || BEAT_COL[1:0] == 2'($past(st_q.start[1:0]) + $past(st_q.beat[1:0]));
  endproperty
  a_seq: assert property (p_seq) else $error("sequential order wrong");

  property p_chop_z;
    @(posedge CLK) disable iff (!NRST)
    BEAT_VALID && !BEAT_IS_WRITE && st_q.chop && st_q.beat > BEATS4 |-> !DQ_OE;
  endproperty
  a_chop_z: assert property (p_chop_z) else $error("chop tail driven");

  property p_qoff;
    @(posedge CLK) disable iff (!NRST) OUTPUTS_OFF |-> !DQ_OE;
  endproperty
  a_qoff: assert property (p_qoff) else $error("driver on while off");

  property p_wcol;
    @(posedge CLK) disable iff (!NRST)
    BEAT_VALID && BEAT_IS_WRITE && !st_q.chop |-> BEAT_COL == 3'(st_q.beat - 4'h1);
  endproperty
  a_wcol: assert property (p_wcol) else $error("write column wrong");

  property p_mr1;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && cmd_mrs && ba_s == BANK_MR1 |=> st_q.mr1 == $past(a_s);
  endproperty
  a_mr1: assert property (p_mr1) else $error("register one not loaded");

  property p_mr0;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && cmd_mrs && ba_s == BANK_MR0 |=> st_q.mr0[MR0_BT] == $past(a_s[MR0_BT]);
  endproperty
  a_mr0: assert property (p_mr0) else $error("register zero not loaded");

  property p_sr;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && sre_s |=> !DLL_ON;
  endproperty
  a_sr: assert property (p_sr) else $error("dll on in self refresh");

  // A queued burst moves into the sequencer
  sequence s_launch;
    !st_q.busy && q.out_valid;
  endsequence

  // A queued write moves into the sequencer
  sequence s_wr_launch;
    !st_q.busy && q.out_valid && q.out_data[CMDW-1];
  endsequence

  property p_slots;
    @(posedge CLK) disable iff (!NRST || !CKE_EN)
    s_launch |=> ##1 BEAT_VALID [*8] ##1 !BEAT_VALID;
  endproperty
  a_slots: assert property (p_slots) else $error("burst slot count wrong");

  property p_chop_oe;
    @(posedge CLK) disable iff (!NRST || !CKE_EN)
    s_launch ##0 (!q.out_data[CMDW-1] && q.out_data[CMDW-2] && !st_q.mr1[MR1_QOFF])
      |=> ##1 DQ_OE [*4] ##1 !DQ_OE [*4];
  endproperty
  a_chop_oe: assert property (p_chop_oe) else $error("chop drive slots wrong");

  property p_ws_fix;
    @(posedge CLK) disable iff (!NRST || !CKE_EN)
    s_wr_launch ##0 (bl_code == BL_FIX4) |-> ##5 WRITE_START;
  endproperty
  a_ws_fix: assert property (p_ws_fix) else $error("fixed chop write start wrong");

  property p_ws_full;
    @(posedge CLK) disable iff (!NRST || !CKE_EN)
    s_wr_launch ##0 (bl_code != BL_FIX4) |-> ##7 WRITE_START;
  endproperty
  a_ws_full: assert property (p_ws_full) else $error("write start point wrong");

  property p_dll_set;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && cmd_mrs && ba_s == BANK_MR0 && a_s[MR0_DLLRST] |=> DLL_RESET_ACTIVE;
  endproperty
  a_dll_set: assert property (p_dll_set) else $error("dll reset not started");

  property p_pd;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && cmd_mrs && ba_s == BANK_MR0 |=> PD_DLL_FAST == $past(a_s[MR0_PPD]);
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown dll mode not loaded");

  property p_srx;
    @(posedge CLK) disable iff (!NRST)
    CKE_EN && srx_s && !sre_s |=> DLL_ON == !st_q.mr1[MR1_DLLDIS];
  endproperty
  a_srx: assert property (p_srx) else $error("dll not back after self refresh");
endmodule

/* File: logic/mode_cfg_pkg.sv */
// Package of constants for the mode register configuration block
package mode_cfg_pkg;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 3;
  localparam int COL_W  = 3;
  // Bank selects for mode register load commands
  localparam logic [2:0] BANK_MR0 = 3'h0;
  localparam logic [2:0] BANK_MR1 = 3'h1;
  // Register zero field positions
  localparam int MR0_BL_LO  = 0;
  localparam int MR0_CL_B0  = 2;
  localparam int MR0_BT     = 3;
  localparam int MR0_CL_LO  = 4;
  localparam int MR0_TM     = 7;
  localparam int MR0_DLLRST = 8;
  localparam int MR0_WR_LO  = 9;
  localparam int MR0_PPD    = 12;
  // Register one field positions
  localparam int MR1_DLLDIS = 0;
  localparam int MR1_DIC0   = 1;
  localparam int MR1_RTT0   = 2;
  localparam int MR1_AL_LO  = 3;
  localparam int MR1_DIC1   = 5;
  localparam int MR1_RTT1   = 6;
  localparam int MR1_WLVL   = 7;
  localparam int MR1_RTT2   = 9;
  localparam int MR1_QOFF   = 12;
  localparam int BC_SEL     = 12;
  // Burst length field codes
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  // Beat counts and write start pull-in
  localparam logic [3:0] BEATS8    = 4'h8;
  localparam logic [3:0] BEATS4    = 4'h4;
  localparam logic [2:0] WR_PULLIN = 3'h2;
  localparam logic [ADDR_W-1:0] REG_RESET = 13'h0000;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {BL8_E, BC4_E} beat_mode_t;
endpackage

/* File: logic/burst_if.sv */
// Interface carrying burst column addresses between the sequencer and its FIFO
`timescale 1ns/1ps
interface burst_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: logic/beat_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module beat_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic CE,
  burst_if.fifo     bus
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_st_t;
  fifo_st_t st_q;
  fifo_st_t st_d;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Honest full and empty from the occupancy count
  assign bus.in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign bus.out_valid = (st_q.cnt != '0);
  assign bus.out_data  = mem[st_q.rp];
  assign push = bus.in_valid & bus.in_ready;
  assign pop  = bus.out_valid & bus.out_ready;

  // Pointer and count update
  always_comb
  begin
    st_d = st_q;
    if (push)
      st_d.wp = st_q.wp + 1'b1;
    if (pop)
      st_d.rp = st_q.rp + 1'b1;
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
      st_q <= '0;
    else if (CE)
      st_q <= st_d;
  end

  // Storage has no reset; contents are qualified by the count
  always_ff @(posedge CLK)
  begin
    if (CE && push)
      mem[st_q.wp] <= bus.in_data;
  end
endmodule

/* File: tb/ctrl_model.sv */
// Memory controller model driving command, address and self refresh pins
`timescale 1ns/1ps
module ctrl_model
  import mode_cfg_pkg::*;
#(
  parameter int LOCK_WAIT = 20
) (
  input  wire logic                           CLK,
  output logic                                CKE_EN,
  output logic                                CS_N,
  output logic                                RAS_N,
  output logic                                CAS_N,
  output logic                                WE_N,
  output logic [mode_cfg_pkg::BANK_W-1:0]     BA,
  output logic [mode_cfg_pkg::ADDR_W-1:0]     ADDR,
  output logic                                SR_ENTER,
  output logic                                SR_EXIT
);
  // Idle pins at time zero; clock enable never drops, lock interval included
  initial
  begin
    CKE_EN = 1'b1;
    {CS_N, RAS_N, CAS_N, WE_N} = 4'h7;
    BA = 3'h0;
    ADDR = 13'h0000;
    SR_ENTER = 1'b0;
    SR_EXIT = 1'b0;
  end

  // One command cycle, then a no-op; address flipped so no stale value lingers
  task automatic issue(input logic [3:0] pins, input logic [BANK_W-1:0] bank,
                       input logic [ADDR_W-1:0] a);
    begin
      @(posedge CLK);
      {CS_N, RAS_N, CAS_N, WE_N} <= pins;
      BA <= bank;
      ADDR <= a;
      @(posedge CLK);
      {CS_N, RAS_N, CAS_N, WE_N} <= 4'h7;
      ADDR <= ~a;
    end
  endtask

  // Mode load: test mode bit and reserved bits always written as zero
  task automatic mrs(input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] v;
    begin
      v = (bank == BANK_MR0) ? (a & 13'h1F7F) : (a & 13'h12FF);
      issue(4'h0, bank, v);
      repeat (4) @(posedge CLK);
    end
  endtask

  // DLL reset, then hold off reads for the whole lock time
  task automatic dll_reset(input logic [ADDR_W-1:0] a);
    begin
      mrs(BANK_MR0, a | 13'h0100);
      repeat (LOCK_WAIT) @(posedge CLK);
    end
  endtask

  // One-cycle self refresh entry or exit pulse
  task automatic sref(input logic enter);
    begin
      @(posedge CLK);
      SR_ENTER <= enter;
      SR_EXIT <= !enter;
      @(posedge CLK);
      SR_ENTER <= 1'b0;
      SR_EXIT <= 1'b0;
    end
  endtask
endmodule

/* File: tb/sdram_mode_reg_burst_dll_config_bench.sv */
// Self-checking bench for the mode register and burst ordering block
`timescale 1ns/1ps
module sdram_mode_reg_burst_dll_config_bench;
  import mode_cfg_pkg::*;
  localparam int RST_CYC = 4;
  logic              CLK, NRST, CKE_EN, CS_N, RAS_N, CAS_N, WE_N, SR_ENTER, SR_EXIT;
  logic [BANK_W-1:0] BA;
  logic [ADDR_W-1:0] ADDR;
  logic              BEAT_VALID, BEAT_IS_WRITE, DQ_OE, BURST_BUSY, WRITE_START, DLL_ON;
  logic              DLL_RESET_ACTIVE, PD_DLL_FAST, WRITE_LEVEL, OUTPUTS_OFF, TEST_MODE;
  logic [COL_W-1:0]  BEAT_COL;
  logic [2:0]        WR_RECOVERY, RTT_NOM;
  logic [3:0]        READ_CL_CODE;
  logic [1:0]        ADD_LAT_CODE, DRIVE_STRENGTH;
  int                fail_count, n_checks, ws, ws_tab[4], ws_otf;

  mode_cfg #(.DLL_RST_CYCLES(RST_CYC)) i_mode_cfg (
    .CLK(CLK), .NRST(NRST), .CKE_EN(CKE_EN), .CS_N(CS_N), .RAS_N(RAS_N),
    .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .SR_ENTER(SR_ENTER),
    .SR_EXIT(SR_EXIT), .BEAT_VALID(BEAT_VALID), .BEAT_COL(BEAT_COL),
    .BEAT_IS_WRITE(BEAT_IS_WRITE), .DQ_OE(DQ_OE), .BURST_BUSY(BURST_BUSY),
    .WRITE_START(WRITE_START), .DLL_ON(DLL_ON), .DLL_RESET_ACTIVE(DLL_RESET_ACTIVE),
    .PD_DLL_FAST(PD_DLL_FAST), .WR_RECOVERY(WR_RECOVERY), .READ_CL_CODE(READ_CL_CODE),
    .ADD_LAT_CODE(ADD_LAT_CODE), .DRIVE_STRENGTH(DRIVE_STRENGTH), .RTT_NOM(RTT_NOM),
    .WRITE_LEVEL(WRITE_LEVEL), .OUTPUTS_OFF(OUTPUTS_OFF), .TEST_MODE(TEST_MODE));

  ctrl_model i_ctrl_model (
    .CLK(CLK), .CKE_EN(CKE_EN), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
    .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .SR_ENTER(SR_ENTER), .SR_EXIT(SR_EXIT));

  // 100 MHz clock
  initial CLK = 1'b0;
  always #5 CLK = ~CLK;

  // Verdict and end of run, shared by timeouts
  task automatic complete_run();
    $display("Checks made: %0d, mismatches: %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Bounded wait on DLL_ON (0), DLL_RESET_ACTIVE (1) or BURST_BUSY (2)
  task automatic await(input int which, input logic v, input int lim);
    logic s;
    begin
      for (int t = 0; t <= lim; t++)
      begin
        @(negedge CLK);
        s = (which == 0) ? DLL_ON : (which == 1) ? DLL_RESET_ACTIVE : BURST_BUSY;
        if (s === v)
          return;
      end
      $display("Error at %0t: wait timed out, got %h expected %h", $time, s, v);
      fail_count++;
      complete_run();
    end
  endtask

  // Expected column of a beat from start column and mode
  function automatic logic [2:0] exp_col(logic [2:0] s, logic [2:0] i, logic wr,
                                         logic chop, logic inter);
    if (wr)
      return chop ? {s[2], 2'h0} + i : i;
    if (inter)
      return s ^ i;
    return {s[2] ^ i[2], s[1:0] + i[1:0]};
  endfunction

  // One read or write burst; ws gets the cycle of the internal write start
  task automatic burst(input logic wr, input logic [ADDR_W-1:0] a, input logic chop,
                       input logic inter);
    int k;
    begin
      k = 0;
      ws = -1;
      fork
        i_ctrl_model.issue(wr ? 4'h4 : 4'h5, 3'h0, a);
      join_none
      for (int t = 0; t < 40 && k < 8; t++)
      begin
        @(negedge CLK);
        if (WRITE_START === 1'b1)
          ws = t;
        if (BEAT_VALID === 1'b1)
        begin
          if (!(wr && chop && k > 3))
            chk(BEAT_COL, exp_col(a[2:0], k[2:0], wr, chop, inter));
          chk({BEAT_IS_WRITE, DQ_OE}, {wr, !wr && !(chop && k > 3)});
          k++;
        end
      end
      chk(16'(k), 16'h0008);
      await(2, 1'b0, 20);
    end
  endtask

  // Register zero burst setup: length code and ordering bit
  task automatic set_mr0(input logic [1:0] bl, input logic bt);
    i_ctrl_model.mrs(BANK_MR0, {9'h000, bt, 1'b0, bl});
  endtask

  // Main sequence
  initial
  begin
    fail_count = 0;
    n_checks = 0;
    NRST = 1'b0;
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    @(negedge CLK);
    chk({DLL_ON, WR_RECOVERY, READ_CL_CODE, PD_DLL_FAST, OUTPUTS_OFF}, 16'h0200);
    chk({BEAT_VALID, DLL_RESET_ACTIVE, TEST_MODE}, 16'h0000);
    // Register one: DLL, drive, termination, latency, leveling, output off
    i_ctrl_model.mrs(BANK_MR1, 13'h004A);
    chk({DLL_ON, DRIVE_STRENGTH, RTT_NOM, ADD_LAT_CODE, WRITE_LEVEL, OUTPUTS_OFF}, 16'h02A4);
    i_ctrl_model.mrs(BANK_MR1, 13'h12A4);
    chk({DLL_ON, DRIVE_STRENGTH, RTT_NOM, ADD_LAT_CODE, WRITE_LEVEL, OUTPUTS_OFF}, 16'h0353);
    i_ctrl_model.mrs(BANK_MR1, 13'h0001);
    chk({DLL_ON, DRIVE_STRENGTH, RTT_NOM, ADD_LAT_CODE, WRITE_LEVEL, OUTPUTS_OFF}, 16'h0000);
    // Register two load, dynamic termination off, must leave register one alone
    i_ctrl_model.mrs(3'h2, 13'h0008);
    chk({DLL_ON, DRIVE_STRENGTH, RTT_NOM, ADD_LAT_CODE, WRITE_LEVEL, OUTPUTS_OFF}, 16'h0000);
    i_ctrl_model.mrs(BANK_MR1, 13'h0052);
    chk({DLL_ON, DRIVE_STRENGTH, RTT_NOM, ADD_LAT_CODE, WRITE_LEVEL, OUTPUTS_OFF}, 16'h02A8);
    // DLL reset after enabling; the reset flag must clear by itself
    fork
      i_ctrl_model.dll_reset(13'h1A54);
      begin
        await(1, 1'b1, 12);
        await(1, 1'b0, RST_CYC + 8);
      end
    join
    chk({WR_RECOVERY, READ_CL_CODE, PD_DLL_FAST, TEST_MODE}, 16'h016E);
    // Fixed lengths, both orders, every start column, one write each
    for (int m = 0; m < 4; m++)
    begin
      set_mr0(m[1] ? BL_FIX4 : BL_FIX8, m[0]);
      for (int s = 0; s < 8; s++)
        burst(1'b0, 13'(s), m[1], m[0]);
      burst(1'b1, 13'h0005, m[1], m[0]);
      ws_tab[m] = ws;
    end
    chk(PD_DLL_FAST, 1'b0);
    // On-the-fly length picked by address bit 12 of each command
    set_mr0(BL_OTF, 1'b0);
    burst(1'b0, 13'h0006, 1'b1, 1'b0);
    burst(1'b0, 13'h1006, 1'b0, 1'b0);
    burst(1'b1, 13'h0003, 1'b1, 1'b0);
    ws_otf = ws;
    chk(16'(ws_otf - ws_tab[2]), 16'(WR_PULLIN));
    chk(16'(ws_otf - ws_tab[0]), 16'h0000);
    // Reserved length code runs as eight beats
    set_mr0(2'h3, 1'b0);
    burst(1'b0, 13'h0003, 1'b0, 1'b0);
    // Self refresh turns the enabled DLL off, then back on
    i_ctrl_model.sref(1'b1);
    await(0, 1'b0, 10);
    i_ctrl_model.sref(1'b0);
    await(0, 1'b1, 10);
    complete_run();
  end
endmodule
